// [power_mode_controller.sv]
/*
 * Power-mode and reset controller: idle and power-down modes, wake-up, pin and power-on reset,
 * analog enables, with the control and status registers reached over a classic Wishbone slave.
 * Assumes the core stalls on core_clk_en, keeps its state while stalled and services the
 * waking interrupt itself; async pins are synchronised here.
 */
// Implementation choices: the placing of the registers and the Wishbone register port.
//
// Behaviour
// R1: Idle keeps oscillator, stops core clock.
// R2: Idle keeps peripheral clock running.
// R3: Idle keeps all core registers intact.
// R4: Idle holds port and converter pins.
// R5: Enabled interrupt or reset ends idle.
// R6: Software selects idle or power-down.
// R7: Power-down stops PLL and core clock.
// R8: Oscillator halt bit stops oscillator in power-down.
// R9: Interval counter keeps its clock in power-down; the code stops it too when the oscillator halt bit is set.
// R10: Other peripherals shut down in power-down.
// R11: Power-down holds ports, floats converter output.
// R12: Reset pin ends power-down, resets registers.
// R13: Power cycle resets, restarts after 128 ms.
// R14: Interval counter interrupt ends power-down.
// R15: Wake resumes after the power-down instruction.
// R16: Serial interrupt wakes only when enabled.
// R17: External pin zero wakes only when enabled.
// R18: Pin zero stays high around entry.
// R19: Supply below threshold holds reset, 128 ms delay.
// R20: Software disables converters and reference individually.
// R21: Wake clears idle and power-down requests.
`timescale 1ns/10ps

module power_mode_controller
  import pmc_pkg::*;
#(
  parameter logic [pmc_pkg::POR_CNT_W-1:0] POR_CYCLES_P = pmc_pkg::POR_CNT_W'(pmc_pkg::POR_CYCLES)
) (
  input  wire logic                clk_i,                  // 25 MHz system clock
  input  wire logic                rst_i,                  // Synchronous reset, active high
  input  wire logic                wb_cyc_i,               // Wishbone cycle
  input  wire logic                wb_stb_i,               // Wishbone strobe
  input  wire logic                wb_we_i,                // Wishbone write enable
  input  wire logic [7:0]          wb_adr_i,               // Wishbone byte address
  input  wire logic [3:0]          wb_sel_i,               // Wishbone byte selects
  input  wire logic [31:0]         wb_dat_i,               // Wishbone write data
  output logic      [31:0]         wb_dat_o,               // Wishbone read data
  output logic                     wb_ack_o,               // Wishbone acknowledge
  input  wire logic                supply_ok_i,            // Supply above reset threshold, async
  input  wire logic                reset_pin_i,            // Reset pin, active high, async
  input  wire logic                ext_int_zero_pin_n_i,   // External interrupt pin zero, active low, async
  input  wire logic                interval_counter_irq_i, // Interval counter interrupt request
  input  wire logic                serial_irq_i,           // Two- or four-wire serial interrupt request
  input  wire logic                enabled_irq_i,          // Any enabled interrupt pending at the core
  output pmc_pkg::clk_gate_t       clk_gate_o,             // Clock enables
  output pmc_pkg::ana_en_t         ana_en_o,               // Converter and reference enables
  output logic                     port_hold_o,            // Freeze port and converter pin states
  output logic                     dac_out_hiz_o,          // Float converter output
  output logic                     sys_rst_o,              // Chip reset to core and registers
  output pmc_pkg::pmode_t          mode_o                  // Current power mode
);

  import pmc_pkg::*;

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [NSYNC-1:0] async_in;
  logic [NSYNC-1:0] sync_meta_q;
  logic [NSYNC-1:0] sync_q;

  assign async_in = {ext_int_zero_pin_n_i, reset_pin_i, supply_ok_i};

  for (genvar g = 0; g < NSYNC; g++) begin : g_sync
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        sync_meta_q[g] <= SYNC_RST[g];
        sync_q[g]      <= SYNC_RST[g];
      end else begin
        sync_meta_q[g] <= async_in[g];
        sync_q[g]      <= sync_meta_q[g];
      end
    end
  end

  logic supply_ok;
  logic rst_pin;
  logic ext_int_act;

  assign supply_ok   = sync_q[SYNC_SUPPLY];
  assign rst_pin     = sync_q[SYNC_RSTPIN];
  assign ext_int_act = ~sync_q[SYNC_EXTINT];

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Power-on reset timer

  logic [POR_CNT_W-1:0] por_cnt_q;
  logic                 por_done_q;
  logic                 reg_rst;
  logic                 sys_rst_q;

  always_ff @(posedge clk_i) begin
    if (rst_i || !supply_ok) begin                               // see R19, see R13
      por_cnt_q  <= '0;
      por_done_q <= 1'b0;
    end else if (!por_done_q) begin
      if (por_cnt_q == POR_CYCLES_P - 1'b1) begin
        por_done_q <= 1'b1;
      end else begin
        por_cnt_q  <= por_cnt_q + 1'b1;
      end
    end
  end

  // Registers and mode return to defaults under pin or power-on reset
  assign reg_rst = rst_i || !por_done_q || rst_pin;              // see R12, see R19

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sys_rst_q <= 1'b1;
    end else begin
      sys_rst_q <= reg_rst;                                      // see R12, see R13
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Register file over Wishbone

  pwr_ctrl_t pwr_q;
  logic      osc_halt_in_powerdown_q;
  ana_en_t   ana_q;
  wake_t     wake_q;
  wake_t     wake_ev;
  pmode_t    mode_q;
  pmode_t    mode_d;
  logic      ack_q;
  logic      [31:0] rdata_q;
  logic      [31:0] rdata_d;
  logic      wr_en;
  logic      wake;

  assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && ack_q && wb_sel_i[0];

  always_comb begin
    rdata_d = RDATA_RST;
    unique case (wb_adr_i)
      ADDR_PWR_CTRL: rdata_d[3:0] = pwr_q;
      ADDR_PLL_CTRL: rdata_d[PLL_OSC_HALT_BIT] = osc_halt_in_powerdown_q;
      ADDR_ANA_EN:   rdata_d[3:0] = ana_q;
      ADDR_STATUS: begin
        rdata_d[1:0]                        = mode_q;
        rdata_d[STS_POR_BIT]                = por_done_q;
        rdata_d[STS_WAKE_LSB+3:STS_WAKE_LSB] = wake_q;
      end
      default:       rdata_d = RDATA_RST;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q   <= 1'b0;
      rdata_q <= RDATA_RST;
    end else begin
      ack_q   <= wb_cyc_i && wb_stb_i && !ack_q;
      if (wb_cyc_i && wb_stb_i && !ack_q) begin
        rdata_q <= rdata_d;
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;

  // Mode requests and wake enables; a wake clears the requests
  always_ff @(posedge clk_i) begin
    if (reg_rst) begin
      pwr_q <= PWR_CTRL_RST;                                     // see R12
    end else if (wake) begin
      pwr_q.idle_req  <= 1'b0;                                   // see R21
      pwr_q.pdown_req <= 1'b0;                                   // see R21
    end else if (wr_en && wb_adr_i == ADDR_PWR_CTRL) begin
      pwr_q <= wb_dat_i[3:0];                                    // see R6
    end
  end

  always_ff @(posedge clk_i) begin
    if (reg_rst) begin
      osc_halt_in_powerdown_q <= PLL_CTRL_RST;
    end else if (wr_en && wb_adr_i == ADDR_PLL_CTRL) begin
      osc_halt_in_powerdown_q <= wb_dat_i[PLL_OSC_HALT_BIT];     // see R8
    end
  end

  always_ff @(posedge clk_i) begin
    if (reg_rst) begin
      ana_q <= ANA_EN_RST;
    end else if (wr_en && wb_adr_i == ADDR_ANA_EN) begin
      ana_q <= wb_dat_i[3:0];                                    // see R20
    end
  end

  // Sticky wake causes, write one to clear; a new cause wins over the clear
  always_ff @(posedge clk_i) begin
    if (reg_rst) begin
      wake_q <= WAKE_RST;
    end else if (wr_en && wb_adr_i == ADDR_STATUS) begin
      wake_q <= (wake_q & ~wb_dat_i[STS_WAKE_LSB+3:STS_WAKE_LSB]) | wake_ev;
    end else begin
      wake_q <= wake_q | wake_ev;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Mode sequencer

  // Pin zero is trusted to stay high around entry, so it is sampled from the first cycle
  always_comb begin
    wake_ev          = WAKE_RST;
    wake_ev.interval = (mode_q == MODE_PDOWN) && interval_counter_irq_i;                    // see R14
    wake_ev.serial   = (mode_q == MODE_PDOWN) && serial_irq_i && pwr_q.serial_wake_enable;  // see R16
    wake_ev.ext_int  = (mode_q == MODE_PDOWN) && ext_int_act
                       && pwr_q.ext_int_zero_wake_enable;                                   // see R17, see R18
    wake_ev.idle_irq = (mode_q == MODE_IDLE) && enabled_irq_i;                              // see R5
  end

  assign wake = |wake_ev;

  always_comb begin
    mode_d = mode_q;
    unique case (mode_q)
      MODE_RUN: begin
        if (pwr_q.pdown_req) begin
          mode_d = MODE_PDOWN;                                   // see R6
        end else if (pwr_q.idle_req) begin
          mode_d = MODE_IDLE;                                    // see R6
        end
      end
      MODE_IDLE: begin
        if (wake) begin
          mode_d = MODE_RUN;                                     // see R5
        end
      end
      MODE_PDOWN: begin
        if (wake) begin
          mode_d = MODE_RUN;                                     // see R14, see R16, see R17
        end
      end
      default: mode_d = MODE_RUN;
    endcase
  end

  // Wake returns the mode to run, reopens the gated clocks and clears the mode requests; no reset, so the core resumes where it stalled
  always_ff @(posedge clk_i) begin
    if (reg_rst) begin
      mode_q <= MODE_RUN;                                        // see R12
    end else begin
      mode_q <= mode_d;                                          // see R3, see R15
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Clock gates and pin control

  logic in_idle;
  logic in_pdown;

  assign in_idle  = (mode_q == MODE_IDLE);
  assign in_pdown = (mode_q == MODE_PDOWN);

  always_comb begin
    clk_gate_o.osc_en          = !(in_pdown && osc_halt_in_powerdown_q);  // see R1, see R8
    clk_gate_o.pll_en          = !in_pdown;                               // see R7
    clk_gate_o.core_clk_en     = !in_idle && !in_pdown;                   // see R1, see R7
    clk_gate_o.periph_clk_en   = !in_pdown;                               // see R2, see R10
    clk_gate_o.interval_clk_en = !(in_pdown && osc_halt_in_powerdown_q);  // see R9
  end

  assign ana_en_o      = in_pdown ? ANA_EN_RST : ana_q;          // see R10, see R20
  assign port_hold_o   = in_idle || in_pdown;                    // see R4, see R11
  assign dac_out_hiz_o = in_pdown;                               // see R11
  assign sys_rst_o     = sys_rst_q;
  assign mode_o        = mode_q;

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reg_rst);

  sequence pdown_write_s;
    wr_en && wb_adr_i == ADDR_PWR_CTRL && wb_dat_i[PWR_PDOWN_BIT] && mode_q == MODE_RUN;
  endsequence

  sequence pdown_wake_s;
    mode_q == MODE_PDOWN && wake;
  endsequence

  sequence idle_wake_s;
    mode_q == MODE_IDLE && wake;
  endsequence

  idle_core_gate_a: assert property (in_idle |-> !clk_gate_o.core_clk_en && clk_gate_o.osc_en) // see R1
    else $error("idle does not gate core clock correctly");

  idle_periph_clk_a: assert property (in_idle |-> clk_gate_o.periph_clk_en && clk_gate_o.pll_en) // see R2
    else $error("idle stopped peripheral clock");

  idle_pins_hold_a: assert property (in_idle |-> port_hold_o && !dac_out_hiz_o) // see R4
    else $error("idle pins not held");

  idle_irq_wake_a: assert property (in_idle && enabled_irq_i |=> mode_q == MODE_RUN) // see R5
    else $error("enabled interrupt did not end idle");

  pdown_entry_a: assert property (pdown_write_s |-> ##2 mode_q == MODE_PDOWN) // see R6
    else $error("power-down request not entered");

  pdown_clocks_a: assert property (in_pdown |-> !clk_gate_o.pll_en && !clk_gate_o.core_clk_en) // see R7
    else $error("power-down left PLL or core clock on");

  osc_halt_a: assert property (in_pdown |-> clk_gate_o.osc_en == !osc_halt_in_powerdown_q) // see R8
    else $error("oscillator state wrong in power-down");

  pdown_periph_a: assert property (in_pdown |-> !clk_gate_o.periph_clk_en && ana_en_o == ANA_EN_RST
                                   && clk_gate_o.interval_clk_en == clk_gate_o.osc_en) // see R9
    else $error("peripheral shutdown wrong in power-down");

  pdown_dac_hiz_a: assert property (dac_out_hiz_o == in_pdown && (!in_pdown || port_hold_o)) // see R11
    else $error("converter output float wrong");

  interval_wake_a: assert property (in_pdown && interval_counter_irq_i |=> mode_q == MODE_RUN) // see R14
    else $error("interval counter interrupt did not wake");

  serial_gate_a: assert property (in_pdown && !interval_counter_irq_i && !wake_ev.ext_int
                                  && !pwr_q.serial_wake_enable |=> in_pdown) // see R16
    else $error("serial interrupt woke without enable");

  ext_gate_a: assert property (in_pdown && !interval_counter_irq_i && !wake_ev.serial
                               && !pwr_q.ext_int_zero_wake_enable |=> in_pdown) // see R17
    else $error("pin zero woke without enable");

  wake_clear_a: assert property (pdown_wake_s |=> mode_q == MODE_RUN && !pwr_q.pdown_req && !pwr_q.idle_req) // see R21
    else $error("wake left a mode request set");

  pin_reset_a: assert property (@(posedge clk_i) disable iff (rst_i)
                                rst_pin |=> sys_rst_o && mode_q == MODE_RUN && pwr_q == PWR_CTRL_RST) // see R12
    else $error("reset pin did not reset");

  supply_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
                                  !supply_ok |=> !por_done_q ##1 sys_rst_o) // see R19
    else $error("low supply did not hold reset");

  idle_wake_clear_a: assert property (idle_wake_s |=> mode_q == MODE_RUN && !pwr_q.idle_req) // see R21
    else $error("idle wake left the idle request set");

  idle_regs_keep_a: assert property (in_idle && !wr_en |=> $stable(ana_q) // see R3
                                     && $stable(osc_halt_in_powerdown_q))
    else $error("idle changed a register");

  wake_no_reset_a: assert property (pdown_wake_s |=> !sys_rst_o) // see R15
    else $error("wake from power-down reset the core");

  interval_clk_a: assert property (in_pdown && !osc_halt_in_powerdown_q |-> clk_gate_o.interval_clk_en) // see R9
    else $error("interval counter clock stopped in power-down");

  serial_wake_a: assert property (in_pdown && serial_irq_i && pwr_q.serial_wake_enable // see R16
                                  |=> mode_q == MODE_RUN)
    else $error("enabled serial interrupt did not wake");

  ext_wake_a: assert property (in_pdown && ext_int_act && pwr_q.ext_int_zero_wake_enable // see R17
                               |=> mode_q == MODE_RUN)
    else $error("enabled pin zero did not wake");

  por_count_a: assert property (@(posedge clk_i) disable iff (rst_i) // see R13
                                !por_done_q && supply_ok && por_cnt_q == POR_CYCLES_P - 1'b1 |=> por_done_q)
    else $error("power-on delay did not end on its count");

  por_release_a: assert property (@(posedge clk_i) disable iff (rst_i) // see R19
                                  por_done_q && !rst_pin |=> !sys_rst_o)
    else $error("reset held after power-on delay");

endmodule : power_mode_controller

// [pmc_pkg.sv]
/*
 * Constants, field layouts and carrier types for the power-mode controller.
 * Assumes a 25 MHz system clock and a classic Wishbone register bus with 32-bit data.
 */
package pmc_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_PWR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_PLL_CTRL   = 8'h04;
  localparam logic [7:0] ADDR_ANA_EN     = 8'h08;
  localparam logic [7:0] ADDR_STATUS     = 8'h0C;

  // Field positions in the power control register
  localparam int         PWR_IDLE_BIT    = 0;
  localparam int         PWR_PDOWN_BIT   = 1;
  localparam int         PWR_SER_BIT     = 2;
  localparam int         PWR_EXT_BIT     = 3;
  // Field position in the PLL control register
  localparam int         PLL_OSC_HALT_BIT = 0;
  // Status fields: mode in [1:0], power-on done in [2], wake causes in [7:4]
  localparam int         STS_POR_BIT     = 2;
  localparam int         STS_WAKE_LSB    = 4;

  // Reset values
  localparam logic [3:0] PWR_CTRL_RST    = 4'h0;
  localparam logic       PLL_CTRL_RST    = 1'b0;
  localparam logic [3:0] ANA_EN_RST      = 4'h0;
  localparam logic [3:0] WAKE_RST        = 4'h0;
  localparam logic [31:0] RDATA_RST      = 32'h0000_0000;

  // Pin synchroniser lanes and their reset levels (interrupt pin idles high)
  localparam int         NSYNC           = 3;
  localparam int         SYNC_SUPPLY     = 0;
  localparam int         SYNC_RSTPIN     = 1;
  localparam int         SYNC_EXTINT     = 2;
  localparam logic [2:0] SYNC_RST        = 3'h4;

  // Power-on delay
  localparam longint unsigned CLK_HZ       = 64'd25_000_000;
  localparam longint unsigned POR_DELAY_MS = 64'd128;
  localparam longint unsigned POR_CYCLES   = (POR_DELAY_MS * CLK_HZ + 64'd999) / 64'd1000;
  localparam int              POR_CNT_W    = 22;

  typedef enum logic [1:0] {
    MODE_RUN   = 2'b00,
    MODE_IDLE  = 2'b01,
    MODE_PDOWN = 2'b10
  } pmode_t;

  typedef struct packed {
    logic ext_int_zero_wake_enable;
    logic serial_wake_enable;
    logic pdown_req;
    logic idle_req;
  } pwr_ctrl_t;

  typedef struct packed {
    logic vref_en;
    logic dac1_en;
    logic dac0_en;
    logic adc_en;
  } ana_en_t;

  typedef struct packed {
    logic osc_en;
    logic pll_en;
    logic core_clk_en;
    logic periph_clk_en;
    logic interval_clk_en;
  } clk_gate_t;

  // Wake cause bits: interval counter, serial, external pin, idle interrupt
  typedef struct packed {
    logic idle_irq;
    logic ext_int;
    logic serial;
    logic interval;
  } wake_t;

endpackage : pmc_pkg

// [pmc_partner.sv]
/*
 * Far-side model: wake sources, the core's pending-interrupt flag and the reset pin.
 * Assumes the bench requests one source at a time with a one-cycle fire pulse.
 */
`timescale 1ns/10ps

module pmc_partner (
  input  wire logic       clk_i,                // System clock
  input  wire logic       rst_i,                // Synchronous reset
  input  wire logic [4:0] fire_i,               // Interval, serial, core irq, pin zero, reset pin
  input  wire logic [2:0] len_i,                // Cycles each request stays asserted
  output logic            interval_irq_o,       // Interval counter interrupt
  output logic            serial_irq_o,         // Serial interrupt
  output logic            core_irq_o,           // Enabled interrupt pending at core
  output logic            ext_int_zero_pin_n_o, // Pin zero, active low
  output logic            reset_pin_o           // Reset pin, active high
);
  logic [2:0] hold_q [5];

  ////////////////////////////////////////////////////////////////////////////
  // Each source stays asserted for len_i cycles after its fire pulse
  always_ff @(posedge clk_i) begin
    for (int k = 0; k < 5; k++) begin
      if (rst_i) begin
        hold_q[k] <= 3'h0;
      end else if (fire_i[k]) begin
        hold_q[k] <= len_i;
      end else if (hold_q[k] != 3'h0) begin
        hold_q[k] <= hold_q[k] - 3'h1;
      end
    end
  end

  assign interval_irq_o       = (hold_q[0] != 3'h0);
  assign serial_irq_o         = (hold_q[1] != 3'h0);
  assign core_irq_o           = (hold_q[2] != 3'h0);
  // Pin zero idles high and only falls when fired, never around entry
  assign ext_int_zero_pin_n_o = (hold_q[3] == 3'h0);
  assign reset_pin_o          = (hold_q[4] != 3'h0);
endmodule : pmc_partner

// [power_mode_controller_tb.sv]
/*
 * Self-checking bench for the power-mode controller over classic Wishbone.
 * Assumes the design and pmc_partner; power-on delay shortened to 20 cycles.
 */
`timescale 1ns/10ps

module power_mode_controller_tb;
  import pmc_pkg::*;
  localparam int POR_P = 20;
  logic clk_i, rst_i, cyc, stb, we, supply_ok, irq_i, irq_s, irq_c, pin_n, rpin, ack, hiz, hold, srst;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, q;
  logic [4:0] fire;
  clk_gate_t g;
  ana_en_t ana;
  pmode_t mode;
  int mismatches, checked, n;

  power_mode_controller #(.POR_CYCLES_P(22'(POR_P))) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .supply_ok_i(supply_ok),
    .reset_pin_i(rpin), .ext_int_zero_pin_n_i(pin_n), .interval_counter_irq_i(irq_i),
    .serial_irq_i(irq_s), .enabled_irq_i(irq_c), .clk_gate_o(g), .ana_en_o(ana),
    .port_hold_o(hold), .dac_out_hiz_o(hiz), .sys_rst_o(srst), .mode_o(mode));

  pmc_partner partner (
    .clk_i(clk_i), .rst_i(rst_i), .fire_i(fire), .len_i(3'h4), .interval_irq_o(irq_i),
    .serial_irq_o(irq_s), .core_irq_o(irq_c), .ext_int_zero_pin_n_o(pin_n), .reset_pin_o(rpin));

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", name, exp, got);
      mismatches++;
    end
  endtask : chk

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hF;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && k < 50);
    if (k >= 50) begin
      $display("ERROR wb_ack expected 1 seen %b", ack);
      mismatches++;
    end
    q = rdat;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask : wb

  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0000_0000);
    chk(name, exp, q);
  endtask : rd_chk

  task automatic kick(input int k);
    @(posedge clk_i);
    fire <= 5'h01 << k;
    @(posedge clk_i);
    fire <= 5'h00;
  endtask : kick

  // Waits a bounded time for the mode, then compares it
  task automatic wait_mode(input string name, input pmode_t m);
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (mode !== m && n < 12);
    chk(name, 32'(m), 32'(mode));
  endtask : wait_mode

  task automatic wait_run_reset;
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (srst !== 1'b0 && n < 200);
  endtask : wait_run_reset

  task automatic final_report;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report

  initial begin
    #(40 * 20000);
    mismatches++;
    final_report();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    mismatches = 0; checked = 0;
    rst_i = 1'b1; supply_ok = 1'b1; fire = 5'h00;
    cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; sel = 4'h0; wdat = 32'h0000_0000;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    wait_run_reset();
    chk("por_release", 32'h0, 32'(srst));
    rd_chk("pwr_rst", ADDR_PWR_CTRL, 32'h0000_0000);
    rd_chk("pll_rst", ADDR_PLL_CTRL, 32'h0000_0000);
    rd_chk("ana_rst", ADDR_ANA_EN, 32'h0000_0000);
    rd_chk("status_rst", ADDR_STATUS, 32'h0000_0004);
    rd_chk("unmapped", 8'h10, 32'h0000_0000);
    // Analog enables set one by one
    for (int b = 0; b < 4; b++) begin
      wb(1'b1, ADDR_ANA_EN, 32'h1 << b);
      @(negedge clk_i);
      chk("ana_en", 32'h1 << b, 32'(ana));
    end
    wb(1'b1, ADDR_ANA_EN, 32'h0000_0005);
    // Idle entry and wake on an enabled interrupt
    wb(1'b1, ADDR_PWR_CTRL, 32'h0000_0001);
    wait_mode("idle", MODE_IDLE);
    chk("idle_clk", 32'h5, {g.osc_en, g.core_clk_en, g.periph_clk_en});
    chk("idle_pins", 32'h1, {hiz, hold});
    kick(0);
    repeat (8) @(negedge clk_i);
    chk("idle_no_wake", 32'(MODE_IDLE), 32'(mode));
    kick(2);
    wait_mode("idle_wake", MODE_RUN);
    rd_chk("idle_req_clr", ADDR_PWR_CTRL, 32'h0000_0000);
    // Power-down, oscillator kept; serial not enabled, interval wakes
    wb(1'b1, ADDR_PWR_CTRL, 32'h0000_0002);
    wait_mode("pdown", MODE_PDOWN);
    chk("pd_clk", 32'h11, 32'(g));
    chk("pd_pins", 32'h3, {hiz, hold});
    chk("pd_ana", 32'h0, 32'(ana));
    kick(1);
    repeat (8) @(negedge clk_i);
    chk("serial_masked", 32'(MODE_PDOWN), 32'(mode));
    kick(0);
    wait_mode("interval_wake", MODE_RUN);
    chk("run_clk", 32'h1F, 32'(g));
    chk("ana_back", 32'h5, 32'(ana));
    rd_chk("pd_req_clr", ADDR_PWR_CTRL, 32'h0000_0000);
    rd_chk("wake_cause", ADDR_STATUS, 32'h0000_0094);
    wb(1'b1, ADDR_STATUS, 32'h0000_00F0);
    rd_chk("wake_clr", ADDR_STATUS, 32'h0000_0004);
    // Oscillator halted, serial wake enabled
    wb(1'b1, ADDR_PLL_CTRL, 32'h0000_0001);
    wb(1'b1, ADDR_PWR_CTRL, 32'h0000_0006);
    wait_mode("pdown_halt", MODE_PDOWN);
    chk("osc_halt", 32'h0, 32'(g.osc_en));
    kick(1);
    wait_mode("serial_wake", MODE_RUN);
    chk("osc_back", 32'h1, 32'(g.osc_en));
    // Pin zero without enable is ignored, reset pin ends power-down
    wb(1'b1, ADDR_PWR_CTRL, 32'h0000_0002);
    wait_mode("pdown_pin", MODE_PDOWN);
    kick(3);
    repeat (8) @(negedge clk_i);
    chk("pin_masked", 32'(MODE_PDOWN), 32'(mode));
    kick(4);
    repeat (4) @(negedge clk_i);
    chk("pin_rst", 32'h1, 32'(srst));
    wait_mode("pin_rst_run", MODE_RUN);
    wait_run_reset();
    rd_chk("pin_rst_ana", ADDR_ANA_EN, 32'h0000_0000);
    rd_chk("pin_rst_pll", ADDR_PLL_CTRL, 32'h0000_0000);
    // Pin zero with enable wakes
    wb(1'b1, ADDR_PWR_CTRL, 32'h0000_000A);
    wait_mode("pdown_ext", MODE_PDOWN);
    kick(3);
    wait_mode("ext_wake", MODE_RUN);
    // Power cycle: supply low holds reset, release after the delay
    wb(1'b1, ADDR_ANA_EN, 32'h0000_000F);
    @(posedge clk_i);
    supply_ok <= 1'b0;
    repeat (6) @(negedge clk_i);
    chk("supply_low", 32'h1, 32'(srst));
    @(posedge clk_i);
    supply_ok <= 1'b1;
    wait_run_reset();
    chk("por_delay", 32'h1, 32'(n >= POR_P + 2 && n <= POR_P + 5));
    rd_chk("por_ana", ADDR_ANA_EN, 32'h0000_0000);
    final_report();
  end
endmodule : power_mode_controller_tb
